// ### rtl/prs_sequencer.sv
/*
 * Resource power sequencer: request gathering, dependency resolution, per-resource
 * on/off timers ticked by the low power oscillator, power modes and shutdown.
 * Assumes all inputs synchronous to clk_i; the oscillator input is sampled, not a clock.
 */
// Implementation choices: the register offsets and strobed register access.
// How it works
// - requests are the union of clock requests, minimum set and request timer.
// - each core clock request maps to a programmable resource mask.
// - each resource holds one of four encoded states.
// - resource timer is zero when settled, nonzero while in transition.
// - timer loads on or off delay, decrements once per oscillator tick.
// - timer reaching zero settles transition_on/off into enabled/disabled.
// - zero on delay goes from disabled straight to enabled.
// - zero off delay goes from enabled straight to disabled.
// - required set recomputed every tick from requests and dependency table.
// - on reaching zero, pending flag clears and on flag inverts.
// - required set compared to status to pick enables and disables.
// - disable only enabled, unrequested resources with no powered dependent.
// - enable only disabled, requested resources with all dependencies enabled.
// - ordering fully programmable via delays and dependencies on oscillator ticks.
// - doze stops main clocks and powers down the radio domain.
// - oscillator keeps feeding the sequencer in doze so it can wake.
// - core state saved before deep sleep, restored on timer or external wake.
// - shutdown tristates all outputs and disables most inputs.
// - power-on from shutdown is a cold start with no kept state.
// - regulator input high enables regulators and releases reset, low holds it.
// - low hibernation input disables regulators through the looped output.
`timescale 1ns/10ps
`include "prs_regs.svh"

module prs_sequencer import prs_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reg_on_i,
   input wire logic hib_reg_on_i,
   input wire logic lpo_clk_i,
   input wire logic [`PRS_NUM_CLKREQ-1:0] clk_req_i,
   input wire logic wake_i,
   input wire logic [31:0] core_state_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   output logic [`PRS_NUM_RES-1:0] res_en_o,
   output logic regulators_en_o,
   output logic device_rst_n_o,
   output logic hib_reg_on_o,
   output logic main_clk_en_o,
   output logic radio_pwr_en_o,
   output logic core_pwr_en_o,
   output logic lpo_seq_en_o,
   output logic retain_save_o,
   output logic retain_restore_o,
   output logic [31:0] core_state_o,
   output logic io_oe_o,
   output logic input_en_o
);

   localparam int NR = `PRS_NUM_RES;
   localparam int NC = `PRS_NUM_CLKREQ;

   logic srst;
   logic lpo_q;
   logic tick;
   logic [1:0] mode_req_q;
   prs_mode_t mode_q;
   logic [NR-1:0] min_set_q;
   logic [NR*NC-1:0] clk_map_q;
   logic [NR-1:0] tmr_mask_q;
   logic [`PRS_REQTMR_W-1:0] tmr_cnt_q;
   logic tmr_expire;
   prs_res_cfg_t res_cfg_q [NR];
   prs_res_state_t state_q [NR];
   logic [`PRS_TMR_W-1:0] timer_q [NR];
   logic [NR-1:0] powered, enabled_v, on_flag, pending;
   logic [NR-1:0] required, deps_met, dependents_up, start_on, start_off;
   logic [31:0] retain_q;
   logic [31:0] core_state_q;
   logic [31:0] rdata_q;
   logic io_en_q;
   logic wr_cfg;
   logic [2:0] cfg_idx;
   logic wake;

   // a low regulator input is a cold restart for every register except the oscillator sampler and the read data register
   assign srst = ~reg_on_i;
   assign regulators_en_o = reg_on_i;
   assign device_rst_n_o = reg_on_i & rst_n_i;
   // only takes effect when looped back to the regulator input on the board
   assign hib_reg_on_o = hib_reg_on_i;

   // oscillator sampled as a level; its rising edge is the sequencer tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lpo_q <= 1'b0;
      end else begin
         lpo_q <= lpo_clk_i;
      end
   end
   assign tick = lpo_clk_i & ~lpo_q & reg_on_i;

   // register writes
   assign cfg_idx = addr_i[4:2];
   assign wr_cfg = wr_i && addr_i >= `PRS_OFF_RES_CFG && addr_i <= `PRS_OFF_RES_CFG_END;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         min_set_q <= `PRS_RST_MIN_SET;
         clk_map_q <= `PRS_RST_CLK_MAP;
      end else if (srst) begin
         min_set_q <= `PRS_RST_MIN_SET;
         clk_map_q <= `PRS_RST_CLK_MAP;
      end else if (wr_i) begin
         if (addr_i == `PRS_OFF_MIN_SET) begin
            min_set_q <= wdata_i[NR-1:0];
         end
         if (addr_i == `PRS_OFF_CLK_MAP) begin
            clk_map_q <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int k = 0; k < NR; k++) begin
            res_cfg_q[k] <= `PRS_RST_RES_CFG;
         end
      end else if (srst) begin
         for (int k = 0; k < NR; k++) begin
            res_cfg_q[k] <= `PRS_RST_RES_CFG;
         end
      end else if (wr_cfg) begin
         res_cfg_q[cfg_idx] <= wdata_i[23:0];
      end
   end

   // resource-request timer: holds its mask asked for until the count runs out
   assign tmr_expire = tick && tmr_cnt_q == `PRS_REQTMR_W'(1);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tmr_mask_q <= '0;
         tmr_cnt_q <= '0;
      end else if (srst) begin
         tmr_mask_q <= '0;
         tmr_cnt_q <= '0;
      end else if (wr_i && addr_i == `PRS_OFF_REQ_TMR) begin
         tmr_mask_q <= wdata_i[`PRS_REQTMR_MASK_LSB +: NR];
         tmr_cnt_q <= wdata_i[`PRS_REQTMR_CNT_LSB +: `PRS_REQTMR_W];
      end else if (tick && tmr_cnt_q != '0) begin
         tmr_cnt_q <= tmr_cnt_q - `PRS_REQTMR_W'(1);
      end
   end

   // request gathering and dependency closure
   always_comb begin
      logic [NR-1:0] need;
      need = min_set_q;
      if (tmr_cnt_q != '0) begin
         need = need | tmr_mask_q;
      end
      for (int c = 0; c < NC; c++) begin
         if (clk_req_i[c]) begin
            need = need | clk_map_q[c*NR +: NR];
         end
      end
      // NR passes reach the longest possible dependency chain
      for (int p = 0; p < NR; p++) begin
         for (int j = 0; j < NR; j++) begin
            if (need[j]) begin
               need = need | res_cfg_q[j].dep;
            end
         end
      end
      required = need;
   end

   always_comb begin
      dependents_up = '0;
      deps_met = '0;
      for (int i = 0; i < NR; i++) begin
         deps_met[i] = (res_cfg_q[i].dep & ~enabled_v) == '0;
         for (int j = 0; j < NR; j++) begin
            if (res_cfg_q[j].dep[i] && powered[j]) begin
               dependents_up[i] = 1'b1;
            end
         end
      end
   end

   assign start_on = required & deps_met;
   assign start_off = ~required & ~dependents_up;

   // per-resource state and countdown timer
   for (genvar i = 0; i < NR; i++) begin : g_res
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            state_q[i] <= RS_DISABLED;
            timer_q[i] <= '0;
         end else if (srst) begin
            state_q[i] <= RS_DISABLED;
            timer_q[i] <= '0;
         end else if (tick) begin
            unique case (state_q[i])
               RS_DISABLED: begin
                  if (start_on[i]) begin
                     if (res_cfg_q[i].t_on == '0) begin
                        state_q[i] <= RS_ENABLED;
                     end else begin
                        state_q[i] <= RS_TRANS_ON;
                        timer_q[i] <= res_cfg_q[i].t_on;
                     end
                  end
               end
               RS_ENABLED: begin
                  if (start_off[i]) begin
                     if (res_cfg_q[i].t_off == '0) begin
                        state_q[i] <= RS_DISABLED;
                     end else begin
                        state_q[i] <= RS_TRANS_OFF;
                        timer_q[i] <= res_cfg_q[i].t_off;
                     end
                  end
               end
               RS_TRANS_ON: begin
                  timer_q[i] <= timer_q[i] - `PRS_TMR_W'(1);
                  if (timer_q[i] == `PRS_TMR_W'(1)) begin
                     state_q[i] <= RS_ENABLED;
                  end
               end
               RS_TRANS_OFF: begin
                  timer_q[i] <= timer_q[i] - `PRS_TMR_W'(1);
                  if (timer_q[i] == `PRS_TMR_W'(1)) begin
                     state_q[i] <= RS_DISABLED;
                  end
               end
            endcase
         end
      end

      // settled states always carry a zero timer, transitions a nonzero one
      assign powered[i] = state_q[i] != RS_DISABLED;
      assign enabled_v[i] = state_q[i] == RS_ENABLED;
      assign pending[i] = state_q[i][1];
      assign on_flag[i] = state_q[i] == RS_ENABLED || state_q[i] == RS_TRANS_OFF;
      assign res_en_o[i] = state_q[i] == RS_ENABLED || state_q[i] == RS_TRANS_ON;
   end

   // power modes
   assign wake = wake_i | tmr_expire;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_req_q <= MR_ACTIVE;
      end else if (srst) begin
         mode_req_q <= MR_ACTIVE;
      end else if (wr_i && addr_i == `PRS_OFF_CTRL) begin
         // a software write beats the wake clear in the same cycle
         mode_req_q <= wdata_i[`PRS_CTRL_MODE_LSB +: 2];
      end else if (wake && mode_q != PM_ACTIVE) begin
         mode_req_q <= MR_ACTIVE;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_q <= PM_ACTIVE;
      end else if (srst) begin
         mode_q <= PM_ACTIVE;
      end else begin
         unique case (mode_q)
            PM_ACTIVE: begin
               if (mode_req_q == MR_DOZE) begin
                  mode_q <= PM_DOZE;
               end else if (mode_req_q == MR_DEEP) begin
                  mode_q <= PM_SAVE;
               end
            end
            PM_DOZE: begin
               if (wake) begin
                  mode_q <= PM_ACTIVE;
               end
            end
            PM_SAVE: begin
               mode_q <= PM_DEEP;
            end
            PM_DEEP: begin
               if (wake) begin
                  mode_q <= PM_RESTORE;
               end
            end
            PM_RESTORE: begin
               mode_q <= PM_ACTIVE;
            end
            default: begin
               mode_q <= PM_ACTIVE;
            end
         endcase
      end
   end

   // retention storage; cleared on cold start, so nothing survives shutdown
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         retain_q <= '0;
         core_state_q <= '0;
      end else if (srst) begin
         retain_q <= '0;
         core_state_q <= '0;
      end else begin
         if (mode_q == PM_SAVE) begin
            retain_q <= core_state_i;
         end
         if (mode_q == PM_RESTORE) begin
            core_state_q <= retain_q;
         end
      end
   end

   assign core_state_o = core_state_q;
   assign retain_save_o = mode_q == PM_SAVE;
   assign retain_restore_o = mode_q == PM_RESTORE;
   assign main_clk_en_o = mode_q == PM_ACTIVE || mode_q == PM_RESTORE;
   assign radio_pwr_en_o = mode_q == PM_ACTIVE;
   assign core_pwr_en_o = mode_q != PM_DEEP;
   assign lpo_seq_en_o = reg_on_i;

   // pads stay released until the regulators are up; no current paths in shutdown
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         io_en_q <= 1'b0;
      end else begin
         io_en_q <= reg_on_i;
      end
   end
   assign io_oe_o = io_en_q & reg_on_i;
   assign input_en_o = io_en_q & reg_on_i;

   // register reads: data stand only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else if (!rd_i) begin
         rdata_q <= '0;
      end else if (addr_i >= `PRS_OFF_RES_CFG && addr_i <= `PRS_OFF_RES_CFG_END) begin
         rdata_q <= {8'h00, res_cfg_q[cfg_idx]};
      end else begin
         unique case (addr_i)
            `PRS_OFF_CTRL: rdata_q <= {29'h0000_0000, mode_q};
            `PRS_OFF_MIN_SET: rdata_q <= {24'h00_0000, min_set_q};
            `PRS_OFF_CLK_MAP: rdata_q <= clk_map_q;
            `PRS_OFF_REQ_TMR: rdata_q <= {8'h00, tmr_cnt_q, tmr_mask_q};
            `PRS_OFF_STATUS: rdata_q <= {5'h00, mode_q, required, pending, on_flag};
            `PRS_OFF_RETAIN: rdata_q <= retain_q;
            default: rdata_q <= '0;
         endcase
      end
   end
   assign rdata_o = rdata_q;

endmodule

// ### rtl/prs_regs.svh
/*
 * Register offsets, field positions and reset values of the resource power sequencer.
 * Assumes inclusion by bare name from the sequencer package and module.
 */
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH

`define PRS_NUM_RES 8
`define PRS_NUM_CLKREQ 4
`define PRS_TMR_W 8
`define PRS_REQTMR_W 16

`define PRS_OFF_CTRL 8'h00
`define PRS_OFF_MIN_SET 8'h04
`define PRS_OFF_CLK_MAP 8'h08
`define PRS_OFF_REQ_TMR 8'h0C
`define PRS_OFF_STATUS 8'h10
`define PRS_OFF_RETAIN 8'h14
`define PRS_OFF_RES_CFG 8'h20
`define PRS_OFF_RES_CFG_END 8'h3C

`define PRS_CTRL_MODE_LSB 0
`define PRS_REQTMR_MASK_LSB 0
`define PRS_REQTMR_CNT_LSB 8
`define PRS_STAT_ON_LSB 0
`define PRS_STAT_PEND_LSB 8
`define PRS_STAT_REQ_LSB 16
`define PRS_STAT_MODE_LSB 24

`define PRS_RST_MIN_SET 8'h01
`define PRS_RST_CLK_MAP 32'h0000_0000
`define PRS_RST_RES_CFG 24'h00_0000

`endif

// ### rtl/prs_pkg.sv
/*
 * Types shared by the resource power sequencer.
 * Assumes prs_regs.svh is on the include path.
 */
`include "prs_regs.svh"

package prs_pkg;

   typedef enum logic [1:0] {
      RS_DISABLED = 2'b00,
      RS_ENABLED = 2'b01,
      RS_TRANS_ON = 2'b10,
      RS_TRANS_OFF = 2'b11
   } prs_res_state_t;

   typedef enum logic [2:0] {
      PM_ACTIVE = 3'b000,
      PM_DOZE = 3'b001,
      PM_SAVE = 3'b010,
      PM_DEEP = 3'b011,
      PM_RESTORE = 3'b100
   } prs_mode_t;

   typedef enum logic [1:0] {
      MR_ACTIVE = 2'b00,
      MR_DOZE = 2'b01,
      MR_DEEP = 2'b10,
      MR_RSVD = 2'b11
   } prs_mode_req_t;

   typedef struct packed {
      logic [`PRS_NUM_RES-1:0] dep;
      logic [`PRS_TMR_W-1:0] t_off;
      logic [`PRS_TMR_W-1:0] t_on;
   } prs_res_cfg_t;

endpackage

// ### testbench/prs_partner.sv
/*
 * Far side of the sequencer: low power oscillator and core clock requesters.
 * Assumes clk_i at 10 MHz; the oscillator is sped up to keep runs short.
 */
`timescale 1ns/10ps
module prs_partner #(
   parameter int HP = 4
) (
   input wire logic clk_i,
   input wire logic [3:0] want_i,
   output logic lpo_clk_o,
   output logic [3:0] clk_req_o
);
   int cnt = 0;
   initial lpo_clk_o = 1'b0;
   initial clk_req_o = 4'h0;
   // free running, never gated, so the sequencer can still wake from doze
   always @(posedge clk_i) begin
      cnt <= (cnt == HP - 1) ? 0 : cnt + 1;
      if (cnt == HP - 1) lpo_clk_o <= ~lpo_clk_o;
   end
   always @(posedge clk_i) clk_req_o <= want_i;
endmodule

// ### testbench/prs_seq_assertions.sv
/*
 * Port relations of the resource power sequencer.
 * Assumes binding to prs_sequencer; one clock domain.
 */
`timescale 1ns/10ps
`include "prs_regs.svh"
module prs_seq_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reg_on_i,
   input wire logic hib_reg_on_i,
   input wire logic lpo_clk_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic [`PRS_NUM_RES-1:0] res_en_o,
   input wire logic regulators_en_o,
   input wire logic device_rst_n_o,
   input wire logic hib_reg_on_o,
   input wire logic main_clk_en_o,
   input wire logic radio_pwr_en_o,
   input wire logic core_pwr_en_o,
   input wire logic lpo_seq_en_o,
   input wire logic retain_save_o,
   input wire logic retain_restore_o,
   input wire logic io_oe_o,
   input wire logic input_en_o
);
   logic lpo_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // cleared by a low regulator input too, so it never hides a real tick
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) lpo_q <= 1'b0;
      else lpo_q <= lpo_clk_i & reg_on_i;
   end
   property p_rst;
      device_rst_n_o == reg_on_i && regulators_en_o == reg_on_i;
   endproperty
   a_rst: assert property (p_rst) else $error("regulator or reset out wrong");
   property p_hib;
      hib_reg_on_o == hib_reg_on_i;
   endproperty
   a_hib: assert property (p_hib) else $error("hibernation loop wrong");
   property p_lpo;
      lpo_seq_en_o == reg_on_i;
   endproperty
   a_lpo: assert property (p_lpo) else $error("oscillator feed wrong");
   property p_pads;
      !reg_on_i |-> !io_oe_o && !input_en_o;
   endproperty
   a_pads: assert property (p_pads) else $error("pads live in shutdown");
   property p_tick;
      $changed(res_en_o) && $past(reg_on_i) |-> $past(lpo_clk_i && !lpo_q);
   endproperty
   a_tick: assert property (p_tick) else $error("enables moved off a tick");
   property p_doze;
      !main_clk_en_o |-> !radio_pwr_en_o;
   endproperty
   a_doze: assert property (p_doze) else $error("radio on without clocks");
   property p_save;
      retain_save_o && reg_on_i |=> !retain_save_o && !core_pwr_en_o && !main_clk_en_o;
   endproperty
   a_save: assert property (p_save) else $error("save not followed by deep");
   property p_rest;
      retain_restore_o |=> !retain_restore_o && radio_pwr_en_o && core_pwr_en_o;
   endproperty
   a_rest: assert property (p_rest) else $error("restore not followed by active");
   property p_rdata;
      !$past(rd_i) |-> rdata_o == 32'h0;
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
endmodule
bind prs_sequencer prs_seq_chk i_chk (.clk_i, .rst_n_i, .reg_on_i, .hib_reg_on_i, .lpo_clk_i,
   .rd_i, .rdata_o, .res_en_o, .regulators_en_o, .device_rst_n_o, .hib_reg_on_o,
   .main_clk_en_o, .radio_pwr_en_o, .core_pwr_en_o, .lpo_seq_en_o, .retain_save_o,
   .retain_restore_o, .io_oe_o, .input_en_o);

// ### testbench/tb.sv
/*
 * Self-checking bench: register port, modes, shutdown, tick-level resource model.
 * Assumes prs_partner supplies the oscillator and the core clock requests.
 */
`timescale 1ns/10ps
module tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, reg_on_i = 1'b1, hib_reg_on_i = 1'b1, wake_i = 1'b0;
   logic wr_i = 1'b0, rd_i = 1'b0, lq, lpo_clk_i;
   logic [7:0] addr_i = 8'h00, res_en_o, mn, rq, dep[8], mp[4], tmask;
   logic [31:0] wdata_i = 32'h0, core_state_i = 32'h0, seed = 32'h0000_67A3, cap, rdata_o;
   logic [31:0] core_state_o;
   logic [3:0] want = 4'h0, clk_req_i;
   logic [15:0] snap;
   logic regulators_en_o, device_rst_n_o, hib_reg_on_o, main_clk_en_o, radio_pwr_en_o;
   logic core_pwr_en_o, lpo_seq_en_o, retain_save_o, retain_restore_o, io_oe_o, input_en_o;
   int error_cnt = 0, check_count = 0, st[8], tm[8], ton[8], toff[8], tcnt;
   always #50 clk_i = ~clk_i;
   prs_partner #(.HP(4)) i_far (.clk_i, .want_i(want), .lpo_clk_o(lpo_clk_i),
      .clk_req_o(clk_req_i));
   prs_sequencer i_dut (.clk_i, .rst_n_i, .reg_on_i, .hib_reg_on_i, .lpo_clk_i, .clk_req_i,
      .wake_i, .core_state_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .res_en_o,
      .regulators_en_o, .device_rst_n_o, .hib_reg_on_o, .main_clk_en_o, .radio_pwr_en_o,
      .core_pwr_en_o, .lpo_seq_en_o, .retain_save_o, .retain_restore_o, .core_state_o,
      .io_oe_o, .input_en_o);
   task automatic chk(logic [31:0] g, logic [31:0] e, string w);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL at %0t: %s got %h expected %h", $time, w, g, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [15:0] stat();
      logic [15:0] s = 16'h0;
      for (int i = 0; i < 8; i++) begin
         s[i] = st[i] == 1 || st[i] == 3;
         s[i + 8] = st[i] >= 2;
      end
      return s;
   endfunction
   function automatic logic [7:0] en_exp();
      logic [7:0] e = 8'h0;
      for (int i = 0; i < 8; i++) e[i] = st[i] == 1 || st[i] == 2;
      return e;
   endfunction
   // decisions use the status from before this tick
   function automatic void tick();
      logic [7:0] en = 8'h0, dp = 8'h0;
      rq = mn;
      if (tcnt > 0) rq |= tmask;
      for (int c = 0; c < 4; c++) if (clk_req_i[c]) rq |= mp[c];
      repeat (8) for (int i = 0; i < 8; i++) if (rq[i]) rq |= dep[i];
      for (int i = 0; i < 8; i++) begin
         en[i] = st[i] == 1;
         if (st[i] != 0) dp |= dep[i];
      end
      for (int i = 0; i < 8; i++) begin
         if (tm[i] > 0) begin
            tm[i]--;
            if (tm[i] == 0) st[i] = st[i] == 2 ? 1 : 0;
         end else if (st[i] == 0 && rq[i] && (dep[i] & ~en) == 8'h0) begin
            tm[i] = ton[i];
            st[i] = ton[i] > 0 ? 2 : 1;
         end else if (st[i] == 1 && !rq[i] && !dp[i]) begin
            tm[i] = toff[i];
            st[i] = toff[i] > 0 ? 3 : 0;
         end
      end
      if (tcnt > 0) tcnt--;
   endfunction
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i || !reg_on_i) begin
         mn = 8'h01;
         // the oscillator sampler only clears on the pin reset, not in shutdown
         lq = rst_n_i ? lpo_clk_i : 1'b0;
         tmask = 8'h00;
         tcnt = 0;
         rq = 8'h00;
         for (int i = 0; i < 8; i++) begin
            st[i] = 0;
            tm[i] = 0;
            ton[i] = 0;
            toff[i] = 0;
            dep[i] = 8'h00;
            mp[i % 4] = 8'h00;
         end
      end else begin
         snap = stat();
         if (lpo_clk_i && !lq) tick();
         lq = lpo_clk_i;
         if (wr_i && addr_i == 8'h04) mn = wdata_i[7:0];
         if (wr_i && addr_i == 8'h0C) begin
            tmask = wdata_i[7:0];
            tcnt = wdata_i[23:8];
         end
         if (wr_i && addr_i == 8'h08) for (int c = 0; c < 4; c++) mp[c] = wdata_i[8*c +: 8];
         if (wr_i && addr_i >= 8'h20 && addr_i <= 8'h3C) begin
            ton[addr_i[4:2]] = wdata_i[7:0];
            toff[addr_i[4:2]] = wdata_i[15:8];
            dep[addr_i[4:2]] = wdata_i[23:16];
         end
      end
   end
   always @(negedge clk_i) if (rst_n_i && reg_on_i) chk(32'(res_en_o), 32'(en_exp()), "en");
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] x, logic [31:0] m, bit s);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(rdata_o & m, (s ? 32'(snap) : x) & m, "read");
   endtask
   task automatic tk(int n);
      repeat (n * 8) @(posedge clk_i);
   endtask
   task automatic wk();
      @(posedge clk_i);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
   endtask
   task automatic wp(bit s);
      int n = 0;
      while (n < 20 && (s ? retain_restore_o : retain_save_o) !== 1'b1) begin
         @(negedge clk_i);
         n++;
      end
      if ((s ? retain_restore_o : retain_save_o) !== 1'b1) begin
         chk(0, 1, "pulse timeout");
         print_verdict();
      end
   endtask
   initial begin
      logic [31:0] r;
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h04, 32'h1, '1, 0);
      rd(8'h08, 32'h0, '1, 0);
      rd(8'h3C, 32'h0, '1, 0);
      rd(8'hFC, 32'h0, '1, 0);
      tk(2);
      rd(8'h10, 32'h0, 32'hFFFF, 1);
      wr(8'h24, 32'h0004_0203);
      wr(8'h28, 32'h0000_0001);
      wr(8'h2C, 32'h0002_0100);
      wr(8'h30, 32'h0000_0202);
      wr(8'h34, 32'h0000_00FF);
      wr(8'h08, 32'h2010_0802);
      for (int k = 0; k < 40; k++) begin
         r = xs();
         want <= r[3:0];
         if (k % 4 == 0) wr(8'h04, {24'h0, r[11:4]});
         tk(1 + r[14:12]);
         rd(8'h10, 32'h0, 32'hFFFF, 1);
      end
      want <= 4'h0;
      wr(8'h04, 32'h0);
      tk(270);
      rd(8'h10, 32'h0, 32'hFFFF, 1);
      wr(8'h00, 32'h1);
      repeat (2) @(negedge clk_i);
      chk(32'({main_clk_en_o, radio_pwr_en_o, core_pwr_en_o, lpo_seq_en_o}), 32'h3, "doze");
      wk();
      repeat (2) @(negedge clk_i);
      chk(32'({main_clk_en_o, radio_pwr_en_o, core_pwr_en_o}), 32'h7, "wake");
      cap = xs();
      @(posedge clk_i);
      core_state_i <= cap;
      wr(8'h00, 32'h2);
      wp(0);
      @(posedge clk_i);
      core_state_i <= ~cap;
      repeat (3) @(negedge clk_i);
      chk(32'({main_clk_en_o, core_pwr_en_o}), 32'h0, "deep");
      wk();
      wp(1);
      repeat (2) @(negedge clk_i);
      chk(core_state_o, cap, "restore");
      wr(8'h0C, 32'h0000_0310);
      wr(8'h00, 32'h2);
      repeat (3) @(negedge clk_i);
      chk(32'({main_clk_en_o, core_pwr_en_o}), 32'h0, "timer deep");
      tk(4);
      @(negedge clk_i);
      chk(32'({main_clk_en_o, radio_pwr_en_o, core_pwr_en_o}), 32'h7, "timer wake");
      chk(core_state_o, ~cap, "timer restore");
      rd(8'h0C, 32'h10, '1, 0);
      rd(8'h10, 32'h0, 32'hFFFF, 1);
      @(posedge clk_i);
      reg_on_i <= 1'b0;
      hib_reg_on_i <= 1'b0;
      @(negedge clk_i);
      chk(32'({io_oe_o, input_en_o, device_rst_n_o, regulators_en_o}), 32'h0, "off");
      repeat (4) @(posedge clk_i);
      reg_on_i <= 1'b1;
      hib_reg_on_i <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk(32'({io_oe_o, input_en_o, device_rst_n_o}), 32'h7, "power on");
      rd(8'h14, 32'h0, '1, 0);
      rd(8'h24, 32'h0, '1, 0);
      rd(8'h10, 32'h0, 32'hFFFF, 1);
      print_verdict();
   end
endmodule
